// ===== logic/sioxr_pkg.sv
// Constants shared by the serial I/O expander readout block
package sioxr_pkg;
   // ***********************************************************
   // Frame layout
   // ***********************************************************
   localparam int FRAME_BITS = 16;       // Bits per chip-select frame
   localparam int CH_LSB = 0;            // Channel field position
   localparam int CH_W = 4;              // Channel field width
   localparam int SET_LSB = 4;           // Setting sub-field position
   localparam int SET_W = 4;             // Setting sub-field width
   localparam int LVL_LSB = 8;           // Analog level byte position
   localparam int PIN_LSB = 4;           // Pin data field position
   localparam int NPIN = 12;             // Expander pins
   localparam int NDUAL = 8;             // Dual-use pins (pins 4 to 11)
   localparam int DUAL_LSB = 4;          // First dual-use pin
   localparam int NDAC = 12;             // Analog channels
   localparam int DAC_W = 8;             // Analog code width
   localparam int CNT_W = 4;             // Link bit counter width
   // ***********************************************************
   // Channel field codes
   // ***********************************************************
   localparam logic [3:0] CH_SPECIAL = 4'h0;  // All-channel functions
   localparam logic [3:0] CH_FIRST_DUAL = 4'h5; // First channel on a dual pin
   localparam logic [3:0] CH_LAST = 4'hC;     // Last analog channel
   localparam logic [3:0] CH_SER2PAR = 4'hD;  // Load parallel outputs
   localparam logic [3:0] CH_PAR2SER = 4'hE;  // Capture pins for readout
   localparam logic [3:0] CH_DIR = 4'hF;      // Load pin direction
   // ***********************************************************
   // Setting sub-field codes
   // ***********************************************************
   localparam logic [3:0] SET_LEVEL = 4'h0;   // Per channel: level
   localparam logic [3:0] SET_HIZ = 4'h1;     // Per channel: standby
   localparam logic [3:0] SP_ALL_LEVEL = 4'hC; // All channels: level
   localparam logic [3:0] SP_ALL_HIZ = 4'hD;  // All dual pins: standby
   localparam logic [3:0] SP_RESET = 4'hE;    // Power-on state
   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [11:0] DIR_RST = 12'h000;  // Direction after reset
   localparam logic [7:0] DAC_RST = 8'h00;     // Analog code after reset
   localparam logic [7:0] SHIFT_HI_RST = 8'h00; // Upper shift byte
   localparam logic [7:0] AO_RST = 8'h00;      // Dual pins not analog
endpackage

// ===== logic/sioxr_top.sv
// Serial I/O expander: pin readout, direction register, power-on state
`timescale 1ns/100ps
module sioxr_top
   import sioxr_pkg::*;
(
   // System clock and reset
   input wire logic MCLK_I,
   input wire logic NRST_I,
   // Host serial link
   input wire logic SCLK_I,
   input wire logic CS_N_I,
   input wire logic SI_I,
   output logic SO_O,
   output logic SO_OE_O,
   // Expander pins
   input wire logic [NPIN-1:0] PIN_I,
   output logic [NPIN-1:0] PIN_O,
   output logic [NPIN-1:0] PIN_OE_O,
   // Analog side
   output logic [NDAC-1:0][DAC_W-1:0] DAC_CODE_O,
   output logic [NDUAL-1:0] AO_EN_O
);
   // ***********************************************************
   // Reset release
   // ***********************************************************
   logic rst_s1_ff; // First reset flop
   logic rst_n_ff; // Released reset for the link and state registers
   // Release is deferred two edges so no flop leaves reset mid-edge
   always_ff @(posedge MCLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         rst_s1_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end
      else
      begin
         rst_s1_ff <= 1'b1;
         rst_n_ff <= rst_s1_ff;
      end
   end

   // ***********************************************************
   // Link domain
   // ***********************************************************
   logic [FRAME_BITS-1:0] sr_ff; // Incoming shift register
   logic [CNT_W-1:0] cnt_ff; // Falling edges seen in this frame
   logic so_ff; // Serial output bit
   logic so_oe_ff; // Serial output driven
   logic [FRAME_BITS-1:0] rd_word; // Word presented to the host
   logic link_clr; // Frame idle or device in reset
   assign link_clr = CS_N_I | ~rst_n_ff;
   // Data enters MSB end so after 16 bits the first bit sits at bit 0
   always_ff @(posedge SCLK_I or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         sr_ff <= '0;
      else if (!CS_N_I)
         sr_ff <= {SI_I, sr_ff[FRAME_BITS-1:1]};
   end
   // Output side; select high ends the frame without needing a clock edge
   always_ff @(negedge SCLK_I or posedge link_clr)
   begin
      if (link_clr)
      begin
         cnt_ff <= '0;
         so_ff <= 1'b0;
         so_oe_ff <= 1'b0;
      end
      else
      begin
         so_ff <= rd_word[cnt_ff];
         so_oe_ff <= 1'b1;
         cnt_ff <= cnt_ff + CNT_W'(1);
      end
   end
   assign SO_O = so_ff;
   assign SO_OE_O = so_oe_ff;

   // ***********************************************************
   // System domain state
   // ***********************************************************
   typedef struct packed {
      logic cs_s1; // Select sync stage 1
      logic cs_s2; // Select sync stage 2
      logic cs_s3; // Select sync stage 3
      logic cs_st; // Settled select level
      logic [NPIN-1:0] pin_s1; // Pin sync stage 1
      logic [NPIN-1:0] pin_s2; // Pin sync stage 2
      logic [NPIN-1:0] pin_s3; // Pin sync stage 3
      logic [NPIN-1:0] pin_st; // Settled pin levels
      logic [NPIN-1:0] dir; // Pin direction register
      logic [NDUAL-1:0] ao_en; // Remembered analog state per dual pin
      logic [NDUAL-1:0] ao_act; // Resolved analog drive
      logic [NDAC-1:0][DAC_W-1:0] dac; // Analog codes
      logic [7:0] shift_hi; // Readout word, upper byte
   } sioxr_st_s;
   sioxr_st_s st_ff; // Registered state
   sioxr_st_s nxt_st; // Next state
   logic [7:0] shift_lo_ff; // Readout low byte, survives power-on
   logic [7:0] nxt_shift_lo; // Next low byte
   logic [NPIN-1:0] par_ff; // Parallel output register, no reset
   logic [NPIN-1:0] nxt_par; // Next parallel outputs
   logic exec; // Command executes this cycle
   logic [3:0] ch; // Channel field of the frame
   logic [3:0] set; // Setting sub-field
   logic [NDUAL-1:0] ao_mask; // Dual pins acting as analog, as pins

   // Dual-pin bit for analog channels 5 to 12 (channel 5 is pin 11)
   function automatic logic [2:0] dual_idx(input logic [3:0] c);
      dual_idx = 3'(CH_LAST - c);
   endfunction

   assign rd_word = {st_ff.shift_hi, shift_lo_ff};
   assign ch = sr_ff[CH_LSB +: CH_W];
   assign set = sr_ff[SET_LSB +: SET_W];
   // The link is quiet while select is high, so sr_ff is stable here
   assign exec = st_ff.cs_s2 & st_ff.cs_s3 & ~st_ff.cs_st;
   assign ao_mask = st_ff.ao_en & ~st_ff.dir[DUAL_LSB +: NDUAL];

   // Next-state decode of synchronisers and commands
   always_comb
   begin
      nxt_st = st_ff;
      nxt_shift_lo = shift_lo_ff;
      nxt_par = par_ff;
      nxt_st.cs_s1 = CS_N_I;
      nxt_st.cs_s2 = st_ff.cs_s1;
      nxt_st.cs_s3 = st_ff.cs_s2;
      nxt_st.pin_s1 = PIN_I;
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.pin_s3 = st_ff.pin_s2;
      // A change counts only once two stages agree
      if (st_ff.cs_s2 == st_ff.cs_s3)
         nxt_st.cs_st = st_ff.cs_s3;
      for (int i = 0; i < NPIN; i++)
      begin
         if (st_ff.pin_s2[i] == st_ff.pin_s3[i])
            nxt_st.pin_st[i] = st_ff.pin_s3[i];
      end
      if (exec)
      begin
         case (ch)
            CH_PAR2SER:
            begin
               // Sample now; host shifts them out next frame
               // Dual pins 11:4 map one to one onto analog mask bits 7:0
               nxt_st.shift_hi = st_ff.pin_st[NPIN-1:DUAL_LSB]
                  & ~st_ff.dir[NPIN-1:DUAL_LSB] & ~ao_mask;
               // Digital-only pins 3:0 never carry an analog output
               nxt_shift_lo = {st_ff.pin_st[DUAL_LSB-1:0] & ~st_ff.dir[DUAL_LSB-1:0],
                  CH_PAR2SER};
            end
            CH_DIR:
               nxt_st.dir = sr_ff[PIN_LSB +: NPIN];
            CH_SER2PAR:
               nxt_par = sr_ff[PIN_LSB +: NPIN];
            CH_SPECIAL:
            begin
               case (set)
                  SP_ALL_LEVEL:
                  begin
                     for (int i = 0; i < NDAC; i++)
                        nxt_st.dac[i] = sr_ff[LVL_LSB +: DAC_W];
                     nxt_st.ao_en = '1;
                  end
                  SP_ALL_HIZ:
                     nxt_st.ao_en = '0;
                  SP_RESET:
                  begin
                     nxt_st.dac = '0;
                     nxt_st.dir = DIR_RST;
                     nxt_st.ao_en = AO_RST;
                  end
                  default:
                     nxt_st.ao_en = st_ff.ao_en; // Don't care codes
               endcase
            end
            default:
            begin
               // Single analog channel 1 to 12
               if (set == SET_LEVEL)
               begin
                  nxt_st.dac[ch - 4'h1] = sr_ff[LVL_LSB +: DAC_W];
                  if (ch >= CH_FIRST_DUAL)
                     nxt_st.ao_en[dual_idx(ch)] = 1'b1;
               end
               else if (set == SET_HIZ && ch >= CH_FIRST_DUAL)
                  nxt_st.ao_en[dual_idx(ch)] = 1'b0;
            end
         endcase
      end
      // Direction one wins; the remembered state returns when it clears
      nxt_st.ao_act = nxt_st.ao_en & ~nxt_st.dir[DUAL_LSB +: NDUAL];
   end

   // State register; power-on values on reset
   always_ff @(posedge MCLK_I or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         st_ff <= '0;
         st_ff.cs_s1 <= 1'b1;
         st_ff.cs_s2 <= 1'b1;
         st_ff.cs_s3 <= 1'b1;
         st_ff.cs_st <= 1'b1;
         st_ff.dir <= DIR_RST;
         st_ff.ao_en <= AO_RST;
         st_ff.ao_act <= AO_RST;
         st_ff.dac <= '0;
         st_ff.shift_hi <= SHIFT_HI_RST;
      end
      else
         st_ff <= nxt_st;
   end

   // Low shift byte and parallel register keep content through power-on
   always_ff @(posedge MCLK_I)
   begin
      shift_lo_ff <= nxt_shift_lo;
      par_ff <= nxt_par;
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign PIN_O = par_ff;
   assign PIN_OE_O = st_ff.dir;
   assign DAC_CODE_O = st_ff.dac;
   assign AO_EN_O = st_ff.ao_act;

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!rst_n_ff);

   a_dir_load: assert property (exec && ch == CH_DIR |=> st_ff.dir == $past(sr_ff[15:4]))
      else $error("direction not loaded");
   a_cap_field: assert property (exec && ch == CH_PAR2SER |=> rd_word[3:0] == CH_PAR2SER)
      else $error("readout channel field wrong");
   a_cap_out_zero: assert property (exec && ch == CH_PAR2SER
      |=> (rd_word[15:4] & $past(st_ff.dir)) == 12'h000)
      else $error("output pin not read as zero");
   a_cap_ao_zero: assert property (exec && ch == CH_PAR2SER
      |=> (rd_word[15:8] & $past(ao_mask[7:0])) == 8'h00)
      else $error("analog pin not read as zero");
   a_ao_prio: assert property ((st_ff.ao_act & st_ff.dir[11:4]) == 8'h00)
      else $error("analog drive on direction-one pin");
   a_ao_restore: assert property (exec && ch == CH_DIR && sr_ff[15:8] == 8'h00
      |=> st_ff.ao_act == st_ff.ao_en)
      else $error("pin state not restored");
   a_level_cmd: assert property (exec && ch == CH_LAST && set == SET_LEVEL
      |=> st_ff.ao_en[0] && st_ff.dac[11] == $past(sr_ff[15:8]))
      else $error("level command not applied");
   a_exec_once: assert property (exec |=> !exec [*2])
      else $error("command executed twice");
   a_par_load: assert property (exec && ch == CH_SER2PAR |=> par_ff == $past(sr_ff[15:4]))
      else $error("parallel register not loaded");
endmodule // sioxr_top

// ===== sim/serial_io_expander_readout_tb.sv
// Self-checking testbench for the serial I/O expander readout
`timescale 1ns/100ps
module serial_io_expander_readout_tb;
   import sioxr_pkg::*;
   // ***********************************************************
   // Signals
   // ***********************************************************
   logic mclk = 1'b0;
   logic nrst_n = 1'b0;
   logic sclk, cs_n, si, so, so_oe;
   logic [NPIN-1:0] pin_in = 12'h000;
   logic [NPIN-1:0] pin_oe;
   logic [NPIN-1:0] pin_out;
   logic [NDAC-1:0][DAC_W-1:0] dac;
   logic [NDUAL-1:0] ao_en;
   logic [15:0] rd;
   logic [11:0] g;
   int fail_count = 0;
   int checks_done = 0;
   // 20 MHz system clock
   always #25 mclk = ~mclk;
   sioxr_top dut_u (.MCLK_I(mclk), .NRST_I(nrst_n), .SCLK_I(sclk), .CS_N_I(cs_n),
      .SI_I(si), .SO_O(so), .SO_OE_O(so_oe), .PIN_I(pin_in), .PIN_O(pin_out),
      .PIN_OE_O(pin_oe), .DAC_CODE_O(dac), .AO_EN_O(ao_en));
   sioxr_host host_u (.SCLK_O(sclk), .CS_N_O(cs_n), .SI_O(si), .SO_I(so),
      .SO_OE_I(so_oe));
   // ***********************************************************
   // Shared tasks
   // ***********************************************************
   // Compare one value, four-state exact
   task automatic chk(input string nm, input logic [95:0] ex, input logic [95:0] got);
      checks_done++;
      if (got !== ex)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // Frame launched just after a system clock edge
   task automatic xfer(input logic [15:0] wd);
      @(posedge mclk);
      #2;
      host_u.frame(wd, rd);
   endtask
   // Capture, change pins, then shift the captured word out
   task automatic read_pins(input logic [11:0] pins, output logic [11:0] got);
      @(posedge mclk);
      #2 pin_in = pins;
      #500;
      xfer({12'h000, CH_PAR2SER});
      pin_in = ~pins;
      xfer(16'h0000);
      chk("channel bits", 96'(CH_PAR2SER), 96'(rd[3:0]));
      chk("so_oe in frame", 96'h1, 96'(host_u.oe_all));
      chk("so_oe idle", 96'h0, 96'(so_oe));
      got = rd[15:4];
   endtask
   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic t_power_on();
      @(posedge mclk);
      #2 nrst_n = 1'b0;
      repeat (10) @(posedge mclk);
      #2 nrst_n = 1'b1;
      repeat (4) @(posedge mclk);
      #2;
      chk("dir", 96'h0, 96'(pin_oe));
      chk("dac", 96'h0, dac);
      chk("ao", 96'h0, 96'(ao_en));
      xfer(16'h0000);
      chk("so upper", 96'h0, 96'(rd[15:8]));
      $display("test power_on done");
   endtask
   task automatic t_readout();
      read_pins(12'hA5C, g);
      chk("pins", 96'h0A5C, 96'(g));
      read_pins(12'h3A1, g);
      chk("pins held", 96'h03A1, 96'(g));
      $display("test readout done");
   endtask
   task automatic t_direction();
      xfer({12'h0F3, CH_DIR});
      chk("dir", 96'h0F3, 96'(pin_oe));
      read_pins(12'hFFF, g);
      chk("output pins", 96'h0F0C, 96'(g));
      xfer({12'h5A3, CH_SER2PAR});
      chk("parallel out", 96'h5A3, 96'(pin_out));
      $display("test direction done");
   endtask
   task automatic t_analog();
      xfer({12'h000, CH_DIR});
      xfer({8'h5A, SET_LEVEL, 4'h5});
      chk("dac5", 96'h5A, 96'(dac[4]));
      chk("ao", 96'h80, 96'(ao_en));
      read_pins(12'hFFF, g);
      chk("analog pin", 96'h7FF, 96'(g));
      xfer({12'h400, CH_DIR});
      xfer({8'h11, SET_LEVEL, 4'h6});
      chk("dac6", 96'h11, 96'(dac[5]));
      chk("dir wins", 96'h80, 96'(ao_en));
      xfer({12'h000, CH_DIR});
      chk("restored", 96'hC0, 96'(ao_en));
      xfer({8'h3C, SET_LEVEL, CH_LAST});
      chk("dac12", 96'h3C, 96'(dac[11]));
      chk("ao pin 4", 96'hC1, 96'(ao_en));
      xfer({8'h00, SET_HIZ, 4'h5});
      chk("ao pin 11 standby", 96'h41, 96'(ao_en));
      $display("test analog done");
   endtask
   task automatic t_special();
      xfer({8'h33, SP_ALL_LEVEL, CH_SPECIAL});
      chk("dac all", {12{8'h33}}, dac);
      chk("ao all", 96'hFF, 96'(ao_en));
      xfer({8'h00, SP_ALL_HIZ, CH_SPECIAL});
      chk("ao standby", 96'h0, 96'(ao_en));
      xfer({12'hFFF, CH_DIR});
      xfer({8'h00, SP_RESET, CH_SPECIAL});
      chk("dir cmd reset", 96'h0, 96'(pin_oe));
      chk("dac cmd reset", 96'h0, dac);
      xfer({8'h77, SP_ALL_LEVEL, CH_SPECIAL});
      xfer({12'h00F, CH_DIR});
      $display("test special done");
   endtask
   // ***********************************************************
   // Closing report
   // ***********************************************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence; second power-on runs with state loaded
   initial
   begin
      t_power_on();
      t_readout();
      t_direction();
      t_analog();
      t_special();
      t_power_on();
      chk("so lower kept", 96'hFE, 96'(rd[7:0]));
      tally_and_finish();
   end
   // Watchdog against a hang
   initial
   begin
      #2_000_000;
      fail_count++;
      $display("[ERR] watchdog expected finish seen hang");
      tally_and_finish();
   end
endmodule // serial_io_expander_readout_tb

// ===== sim/sioxr_host.sv
// Host model: drives chip select, shift clock and serial data in
`timescale 1ns/100ps
module sioxr_host
(
   // Serial link towards the device
   output logic SCLK_O,
   output logic CS_N_O,
   output logic SI_O,
   input wire logic SO_I,
   input wire logic SO_OE_I
);
   // Low if the output enable dropped at any sample of any frame
   logic oe_all;
   // Link idles with clock still and chip select high
   initial
   begin
      SCLK_O = 1'b0;
      CS_N_O = 1'b1;
      SI_O = 1'b0;
      oe_all = 1'b1;
   end
   // One 16-bit frame, bit 0 first, 15 ns shift clock; rd holds SO
   task automatic frame(input logic [15:0] wd, output logic [15:0] rd);
      CS_N_O = 1'b0;
      #11;
      for (int k = 0; k < 16; k++)
      begin
         SI_O = wd[k];
         #3.75 SCLK_O = 1'b1;
         #7.5 SCLK_O = 1'b0;
         // Sampled midway through the low phase, where SO has settled
         // An undriven line reads inverted, so it can never pass a compare
         #3.75 rd[k] = SO_OE_I ? SO_I : ~SO_I;
         oe_all = oe_all & SO_OE_I;
      end
      CS_N_O = 1'b1;
      // Released data line toggles so no stale level is trusted
      SI_O = ~SI_O;
      // Gap lets the command execute in the system clock domain
      #400;
   endtask
endmodule // sioxr_host
